// [nadr_consts.vh]
/*
  Constants for the queued non-data responder: subcommand and abort codes,
  command field positions, frame status bits and error codes.
  Assumes inclusion by bare name from the responder modules.
*/
`ifndef NADR_CONSTS_VH
`define NADR_CONSTS_VH

`define NADR_SUB_ABORT 4'h0
`define NADR_SUB_DEADLINE 4'h1
`define NADR_ABT_ALL 4'h0
`define NADR_ABT_STREAM 4'h1
`define NADR_ABT_NONSTREAM 4'h2
`define NADR_ABT_SELECTED 4'h3
`define NADR_FEAT_SUB_LSB 0
`define NADR_FEAT_SUB_MSB 3
`define NADR_FEAT_WNC_BIT 4
`define NADR_FEAT_RNC_BIT 5
`define NADR_FEAT_ABT_LSB 4
`define NADR_FEAT_ABT_MSB 7
`define NADR_COMMAND_PRIORITY_DEADLINE 2'h1
`define NADR_ERR_NONE 8'h00
`define NADR_ERR_ABORTED 8'h04
`define NADR_ST_ERR 0
`define NADR_ST_DRQ 3
`define NADR_ST_BIT4 4
`define NADR_ST_DF 5
`define NADR_ST_DRIVE_READY_FLAG 6
`define NADR_ST_BSY 7
`define NADR_STATUS_OK 8'h40
`define NADR_STATUS_ERR 8'h41

`endif

// [nadr_tag_table.v]
/*
  Per-tag outstanding table: one flip-flop set per tag holding busy,
  streaming kind, read/write, deadline priority and a completion timer.
  Assumes the caller presents at most one new tag per cycle.
*/
`timescale 1ns/1ps
`include "nadr_consts.vh"
module nadr_tag_table #(
  parameter TAGS = 32,
  parameter TW = 16
) (
  input wire clk_sys,
  input wire rst_n,
  input wire add_valid,
  input wire [4:0] add_tag,
  input wire add_stream,
  input wire add_write,
  input wire [1:0] add_command_priority,
  input wire [TW-1:0] add_limit,
  input wire [TAGS-1:0] done_mask,
  input wire [TAGS-1:0] clear_mask,
  input wire rd_no_continue,
  input wire wr_no_continue,
  output wire [TAGS-1:0] outstanding,
  output wire [TAGS-1:0] streaming,
  output wire deadline_miss
);
  wire [TAGS-1:0] miss;
  genvar i;
  generate
    for (i = 0; i < TAGS; i = i + 1) begin : g_tag
      reg busy;
      reg strm;
      reg wr;
      reg [1:0] command_priority;
      reg [TW-1:0] timer;
      wire hit = add_valid && (add_tag == i);
      always @(posedge clk_sys) begin
        if (!rst_n) begin
          busy <= 1'b0;
          strm <= 1'b0;
          wr <= 1'b0;
          command_priority <= 2'h0;
          timer <= {TW{1'b0}};
        end else if (clear_mask[i] || done_mask[i]) begin
          busy <= 1'b0;
        end else if (hit) begin
          busy <= 1'b1;
          strm <= add_stream;
          wr <= add_write;
          command_priority <= add_command_priority;
          timer <= add_limit;
        end else if (busy && timer != {TW{1'b0}}) begin
          timer <= timer - {{(TW-1){1'b0}}, 1'b1};
        end
      end
      assign miss[i] = busy && strm && (command_priority == `NADR_COMMAND_PRIORITY_DEADLINE) &&
        (timer == {TW{1'b0}}) && (wr ? wr_no_continue : rd_no_continue);
      assign outstanding[i] = busy;
      assign streaming[i] = strm;
    end
  endgenerate
  assign deadline_miss = |miss;
endmodule // nadr_tag_table

// [nadr_frame_out.v]
/*
  Frame output stage: holds one device-to-host frame (set-bits or register)
  until the link takes it.
  Assumes the link accepts a frame with a one-cycle take pulse.
*/
`timescale 1ns/1ps
`include "nadr_consts.vh"
module nadr_frame_out (
  input wire clk_sys,
  input wire rst_n,
  input wire load,
  input wire load_is_reg,
  input wire [7:0] load_error,
  input wire [7:0] load_status,
  input wire [31:0] load_act,
  input wire frame_take,
  output reg frame_valid,
  output reg frame_is_reg,
  output reg [7:0] frame_error,
  output reg [7:0] frame_status,
  output reg frame_intr,
  output reg [31:0] frame_act,
  output wire sent
);
  assign sent = frame_valid && frame_take;
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      frame_valid <= 1'b0;
      frame_is_reg <= 1'b0;
      frame_error <= 8'h00;
      frame_status <= 8'h00;
      frame_intr <= 1'b0;
      frame_act <= 32'h00000000;
    end else if (load) begin
      frame_valid <= 1'b1;
      frame_is_reg <= load_is_reg;
      frame_error <= load_error;
      frame_status <= load_status;
      frame_intr <= 1'b1;
      frame_act <= load_is_reg ? 32'h00000000 : load_act;
    end else if (sent) begin
      frame_valid <= 1'b0;
    end
  end
endmodule // nadr_frame_out

// [nadr_responder.v]
/*
  Queued non-data responder: decodes abort-queue and deadline subcommands,
  keeps the deadline settings, builds completion and error frames and holds
  queued processing after an error until the error log is read.
  Assumes the command layer presents decoded fields with a one-cycle strobe
  and that the link takes frames with frame_take.
*/
// Operation
// - Success set-bits frame carries zero error
// - Success clears error, sets interrupt
// - Completion field is 32-bit tag vector
// - Completions may be aggregated per frame
// - Abort completes aborted tags plus own
// - Reject abort: own tag or bad type
// - Error before busy clear: register frame
// - Register error status busy0 ready1 err1
// - Halt after error until log read
// - Later error: set-bits frame with error
// - Outstanding aborted, completion bits zero
// - Busy clear: only set-bits fields change
// - Busy set: register frame clears busy
// - Subcommand 1h selects deadline handling
// - Read deadline miss aborts all outstanding
// - Write deadline miss aborts all outstanding
// - Ignore settings unless priority is 01b
// - Settings survive soft resets, not power
// - Deadline completes, sets own tag bit
// - Abort types 0h-3h decoded, rest reserved
// - Supported abort succeeds even if none
`timescale 1ns/1ps
`include "nadr_consts.vh"
module nadr_responder #(
  parameter TW = 16
) (
  input wire clk_sys,
  input wire rst_n,
  input wire power_on_rst_n,
  input wire cmd_valid,
  input wire [7:0] cmd_features,
  input wire [4:0] cmd_tag,
  input wire [4:0] cmd_target_tag,
  input wire cmd_busy_set,
  input wire q_valid,
  input wire [4:0] q_tag,
  input wire q_stream,
  input wire q_write,
  input wire [1:0] q_command_priority,
  input wire [TW-1:0] q_limit,
  input wire [31:0] q_done,
  input wire ext_error,
  input wire [7:0] ext_error_code,
  input wire ext_busy_set,
  input wire error_log_read,
  input wire frame_take,
  output reg cmd_ready,
  output reg halted,
  output reg read_deadline_no_continue,
  output reg write_deadline_no_continue,
  output reg [31:0] outstanding_tags,
  output wire frame_valid,
  output wire frame_is_reg,
  output wire [7:0] frame_error,
  output wire [7:0] frame_status,
  output wire frame_intr,
  output wire [31:0] frame_act
);
  localparam S_IDLE = 2'h0;
  localparam S_SEND = 2'h1;
  localparam S_HALT = 2'h2;

  reg [1:0] state;
  reg [1:0] next_state;
  reg halt_after;
  reg next_halt_after;
  reg load;
  reg load_is_reg;
  reg [7:0] load_error;
  reg [7:0] load_status;
  reg [31:0] load_act;
  reg [31:0] clear_mask;
  reg rnc_set;
  reg wnc_set;
  reg rnc_val;
  reg wnc_val;
  wire [31:0] outstanding;
  wire [31:0] streaming;
  wire deadline_miss;
  wire sent;
  reg [31:0] done_pend;
  wire [31:0] done_new = q_done & outstanding;
  wire [31:0] done_mask = done_new | done_pend;
  wire [3:0] sub = cmd_features[`NADR_FEAT_SUB_MSB:`NADR_FEAT_SUB_LSB];
  wire [3:0] abt = cmd_features[`NADR_FEAT_ABT_MSB:`NADR_FEAT_ABT_LSB];
  wire [31:0] own_bit = 32'h00000001 << cmd_tag;
  wire [31:0] target_bit = 32'h00000001 << cmd_target_tag;

  nadr_tag_table #(
    .TAGS(32),
    .TW(TW)
  ) u_tags (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .add_valid(q_valid && !halted),
    .add_tag(q_tag),
    .add_stream(q_stream),
    .add_write(q_write),
    .add_command_priority(q_command_priority),
    .add_limit(q_limit),
    .done_mask(done_mask),
    .clear_mask(clear_mask),
    .rd_no_continue(read_deadline_no_continue),
    .wr_no_continue(write_deadline_no_continue),
    .outstanding(outstanding),
    .streaming(streaming),
    .deadline_miss(deadline_miss)
  );

  nadr_frame_out u_frame (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .load(load),
    .load_is_reg(load_is_reg),
    .load_error(load_error),
    .load_status(load_status),
    .load_act(load_act),
    .frame_take(frame_take),
    .frame_valid(frame_valid),
    .frame_is_reg(frame_is_reg),
    .frame_error(frame_error),
    .frame_status(frame_status),
    .frame_intr(frame_intr),
    .frame_act(frame_act),
    .sent(sent)
  );

  always @* begin
    next_state = state;
    next_halt_after = halt_after;
    load = 1'b0;
    load_is_reg = 1'b0;
    load_error = `NADR_ERR_NONE;
    load_status = `NADR_STATUS_OK;
    load_act = 32'h00000000;
    clear_mask = 32'h00000000;
    rnc_set = 1'b0;
    wnc_set = 1'b0;
    rnc_val = 1'b0;
    wnc_val = 1'b0;
    case (state)
      S_IDLE: begin
        if (ext_error || (deadline_miss && !cmd_valid)) begin
          clear_mask = outstanding;
          load = 1'b1;
          load_error = ext_error ? ext_error_code : `NADR_ERR_ABORTED;
          load_status = `NADR_STATUS_ERR;
          load_is_reg = ext_error && ext_busy_set;
          load_act = 32'h00000000;
          next_halt_after = 1'b1;
          next_state = S_SEND;
        end else if (cmd_valid) begin
          load = 1'b1;
          next_state = S_SEND;
          if (sub == `NADR_SUB_ABORT) begin
            if ((abt == `NADR_ABT_SELECTED && cmd_target_tag == cmd_tag) ||
                abt > `NADR_ABT_SELECTED) begin
              load_is_reg = cmd_busy_set;
              load_error = `NADR_ERR_ABORTED;
              load_status = `NADR_STATUS_ERR;
              clear_mask = outstanding;
              next_halt_after = 1'b1;
            end else begin
              case (abt)
                `NADR_ABT_ALL: clear_mask = outstanding;
                `NADR_ABT_STREAM: clear_mask = outstanding & streaming;
                `NADR_ABT_NONSTREAM: clear_mask = outstanding & ~streaming;
                default: clear_mask = outstanding & target_bit;
              endcase
              load_act = clear_mask | own_bit | done_mask;
              next_halt_after = 1'b0;
            end
          end else if (sub == `NADR_SUB_DEADLINE) begin
            rnc_set = 1'b1;
            wnc_set = 1'b1;
            rnc_val = cmd_features[`NADR_FEAT_RNC_BIT];
            wnc_val = cmd_features[`NADR_FEAT_WNC_BIT];
            load_act = own_bit | done_mask;
            next_halt_after = 1'b0;
          end else begin
            load_is_reg = cmd_busy_set;
            load_error = `NADR_ERR_ABORTED;
            load_status = `NADR_STATUS_ERR;
            clear_mask = outstanding;
            next_halt_after = 1'b1;
          end
        end else if (done_mask != 32'h00000000) begin
          load = 1'b1;
          load_act = done_mask;
          next_halt_after = 1'b0;
          next_state = S_SEND;
        end
      end
      S_SEND: begin
        if (sent) begin
          next_state = halt_after ? S_HALT : S_IDLE;
        end
      end
      S_HALT: begin
        clear_mask = outstanding;
        if (error_log_read) begin
          next_state = S_IDLE;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= S_IDLE;
      halt_after <= 1'b0;
      cmd_ready <= 1'b0;
      halted <= 1'b0;
      outstanding_tags <= 32'h00000000;
      done_pend <= 32'h00000000;
    end else begin
      state <= next_state;
      halt_after <= next_halt_after;
      cmd_ready <= (next_state == S_IDLE);
      halted <= (next_state == S_HALT);
      outstanding_tags <= outstanding & ~clear_mask & ~done_mask;
      if (state == S_SEND) begin
        done_pend <= done_pend | done_new;
      end else begin
        done_pend <= 32'h00000000;
      end
    end
  end

  always @(posedge clk_sys) begin
    if (!power_on_rst_n) begin
      read_deadline_no_continue <= 1'b0;
      write_deadline_no_continue <= 1'b0;
    end else begin
      if (rnc_set) begin
        read_deadline_no_continue <= rnc_val;
      end
      if (wnc_set) begin
        write_deadline_no_continue <= wnc_val;
      end
    end
  end
endmodule // nadr_responder

// [nadr_assertions.sv]
/* Port checker for the queued non-data responder.
   Assumes a bind onto every responder instance. */
`timescale 1ns/1ps
module nadr_assertions (
  input wire clk_sys,
  input wire rst_n,
  input wire power_on_rst_n,
  input wire cmd_valid,
  input wire [7:0] cmd_features,
  input wire [4:0] cmd_tag,
  input wire cmd_busy_set,
  input wire ext_error,
  input wire error_log_read,
  input wire frame_take,
  input wire cmd_ready,
  input wire halted,
  input wire read_deadline_no_continue,
  input wire write_deadline_no_continue,
  input wire frame_valid,
  input wire frame_is_reg,
  input wire [7:0] frame_error,
  input wire [7:0] frame_status,
  input wire frame_intr,
  input wire [31:0] frame_act
);
  wire go = cmd_valid && cmd_ready && !ext_error;
  wire rnc_in = cmd_features[5];
  wire wnc_in = cmd_features[4];
  ok_frame_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frame_valid && !frame_status[0] |-> !frame_is_reg && frame_error == 8'h00 && frame_intr
    && frame_status == 8'h40) else $error("success frame fields wrong");
  hold_frame_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frame_valid && !frame_take |=> frame_valid && $stable(frame_act) && $stable(frame_status))
    else $error("frame changed before take");
  abort_own_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    go && cmd_features == 8'h00 |=> frame_valid && !frame_is_reg && frame_act[$past(cmd_tag)])
    else $error("abort own tag bit missing");
  reg_on_busy_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    go && cmd_busy_set && cmd_features[3:0] == 4'h0 && cmd_features[7:4] > 4'h3
    |=> frame_valid && frame_is_reg && frame_error == 8'h04) else $error("bad type not refused");
  reg_frame_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frame_valid && frame_is_reg |-> frame_status == 8'h41 && frame_act == 32'h0)
    else $error("register frame status wrong");
  halt_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frame_valid && frame_take && frame_status[0] |=> ##[0:1] halted) else $error("no halt");
  halt_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    halted && !error_log_read |=> halted && !cmd_ready) else $error("halt left early");
  err_sdb_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frame_valid && frame_status[0] && !frame_is_reg |-> frame_act == 32'h0 && frame_intr
    && frame_error != 8'h00) else $error("error set-bits frame wrong");
  dl_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    go && cmd_features[3:0] == 4'h1 |=> frame_status == 8'h40 && read_deadline_no_continue
    == $past(rnc_in) && write_deadline_no_continue == $past(wnc_in)) else $error("deadline set");
  keep_bits_a: assert property (@(posedge clk_sys) disable iff (!power_on_rst_n)
    !rst_n |=> $stable(read_deadline_no_continue) && $stable(write_deadline_no_continue))
    else $error("deadline bits lost in reset");
endmodule // nadr_assertions
bind nadr_responder nadr_assertions nadr_assertions_inst (.clk_sys, .rst_n, .power_on_rst_n,
  .cmd_valid, .cmd_features, .cmd_tag, .cmd_busy_set, .ext_error, .error_log_read,
  .frame_take, .cmd_ready, .halted, .read_deadline_no_continue, .write_deadline_no_continue,
  .frame_valid, .frame_is_reg, .frame_error, .frame_status, .frame_intr, .frame_act);

// [nadr_host_model.sv]
/* Host side frame taker: takes each held frame after a set stall.
   Assumes frames stand until the take pulse. */
`timescale 1ns/1ps
module nadr_host_model (
  input wire clk_sys,
  input wire rst_n,
  input wire frame_valid,
  input wire [3:0] stall,
  output reg frame_take
);
  reg [3:0] wait_cnt;
  always @(negedge clk_sys) begin
    if (!rst_n || !frame_valid || frame_take) begin
      frame_take <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (wait_cnt == stall) begin
      frame_take <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule // nadr_host_model

// [nadr_responder_tb.sv]
/* Bench for the responder: aborts, refusals, errors, deadlines, resets.
   Assumes the host model takes frames. */
`timescale 1ns/1ps
module nadr_responder_tb;
  logic clk_sys = 0, rst_n = 0, power_on_rst_n = 0, cmd_valid = 0, cmd_busy_set = 0;
  logic q_valid = 0, q_stream = 0, q_write = 0, ext_error = 0, ext_busy_set = 0;
  logic error_log_read = 0;
  logic [7:0] cmd_features = 0, ext_error_code = 0;
  logic [4:0] cmd_tag = 0, cmd_target_tag = 0, q_tag = 0;
  logic [1:0] q_command_priority = 0;
  logic [15:0] q_limit = 0;
  logic [31:0] q_done = 0;
  logic [3:0] stall = 0;
  wire frame_take, cmd_ready, halted, read_deadline_no_continue, write_deadline_no_continue;
  wire frame_valid, frame_is_reg, frame_intr;
  wire [7:0] frame_error, frame_status;
  wire [31:0] outstanding_tags, frame_act;
  int n_fail = 0, n_checks = 0;
  nadr_responder #(.TW(16)) nadr_responder_inst (.clk_sys, .rst_n, .power_on_rst_n,
    .cmd_valid, .cmd_features, .cmd_tag, .cmd_target_tag, .cmd_busy_set, .q_valid, .q_tag,
    .q_stream, .q_write, .q_command_priority, .q_limit, .q_done, .ext_error, .ext_error_code,
    .ext_busy_set, .error_log_read, .frame_take, .cmd_ready, .halted,
    .read_deadline_no_continue, .write_deadline_no_continue, .outstanding_tags,
    .frame_valid, .frame_is_reg, .frame_error, .frame_status, .frame_intr, .frame_act);
  nadr_host_model nadr_host_model_inst (.clk_sys, .rst_n, .frame_valid, .stall, .frame_take);
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic summarize();
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // Host keeps tags unique among outstanding ones
  task automatic q_add(input logic [4:0] t, input logic s, w, input logic [1:0] p);
    q_tag = t;
    q_stream = s;
    q_write = w;
    q_command_priority = p;
    q_limit = 16'h0005;
    q_valid = 1;
    settle(1);
    q_valid = 0;
    settle(1);
  endtask
  task automatic cmd(input logic [7:0] f, input logic [4:0] t, tt, input logic b);
    int i = 0;
    while (cmd_ready !== 1'b1 && i < 300) begin
      settle(1);
      i++;
    end
    chk("cmd_ready", 1, cmd_ready);
    cmd_features = f;
    cmd_tag = t;
    cmd_target_tag = tt;
    cmd_busy_set = b;
    cmd_valid = 1;
    settle(1);
    cmd_valid = 0;
  endtask
  task automatic frm(input logic r, input logic [7:0] e, input logic [31:0] a);
    int i = 0;
    while (frame_valid !== 1'b1 && i < 300) begin
      settle(1);
      i++;
    end
    chk("frame_valid", 1, frame_valid);
    chk("frame_is_reg", r, frame_is_reg);
    chk("frame_error", e, frame_error);
    chk("frame_status", e ? 8'h41 : 8'h40, frame_status);
    chk("frame_intr", 1, frame_intr);
    chk("frame_act", a, frame_act);
    while (frame_valid === 1'b1 && i < 600) begin
      settle(1);
      i++;
    end
    settle(1);
  endtask
  task automatic unhalt();
    settle(3);
    chk("halted", 1, halted);
    chk("cmd_ready", 0, cmd_ready);
    cmd_features = 8'h00;
    cmd_tag = 9;
    cmd_valid = 1;
    settle(1);
    cmd_valid = 0;
    settle(4);
    chk("frame_valid", 0, frame_valid);
    error_log_read = 1;
    settle(1);
    error_log_read = 0;
    settle(3);
    chk("halted", 0, halted);
    chk("cmd_ready", 1, cmd_ready);
  endtask
  task automatic t_abort();
    logic [31:0] ea[4] = '{32'h26, 32'h22, 32'h24, 32'h24};
    logic [31:0] ra[4] = '{32'h40, 32'h44, 32'h42, 32'h42};
    for (int k = 0; k < 4; k++) begin
      q_add(1, 1, 0, 2'h0);
      q_add(2, 0, 1, 2'h0);
      cmd({k[3:0], 4'h0}, 5, 2, 0);
      frm(0, 8'h00, ea[k]);
      cmd(8'h00, 6, 0, 0);
      frm(0, 8'h00, ra[k]);
    end
    cmd(8'h00, 8, 0, 1);
    frm(0, 8'h00, 32'h100);
    // Completion arriving while a frame is held
    q_add(7, 0, 0, 2'h0);
    cmd(8'h30, 8, 1, 1);
    q_done = 32'h80;
    frm(0, 8'h00, 32'h100);
    q_done = 0;
    frm(0, 8'h00, 32'h80);
    q_add(7, 0, 0, 2'h0);
    q_done = 32'h80;
    settle(1);
    q_done = 0;
    frm(0, 8'h00, 32'h80);
  endtask
  task automatic t_reject();
    logic [7:0] fa[3] = '{8'h40, 8'h30, 8'h02};
    logic ba[3] = '{1, 0, 1};
    for (int k = 0; k < 3; k++) begin
      cmd(fa[k], 5, 5, ba[k]);
      frm(ba[k], 8'h04, 0);
      unhalt();
    end
    for (int b = 0; b < 2; b++) begin
      ext_error_code = 8'h51;
      ext_busy_set = b[0];
      ext_error = 1;
      settle(1);
      ext_error = 0;
      frm(b[0], 8'h51, 0);
      unhalt();
    end
  endtask
  task automatic t_dead();
    for (int w = 0; w < 2; w++) begin
      cmd(w ? 8'h11 : 8'h21, 3, 0, 0);
      frm(0, 8'h00, 32'h8);
      chk("rd_nc", !w, read_deadline_no_continue);
      chk("wr_nc", w, write_deadline_no_continue);
      q_add(4, 1, w[0], 2'h1);
      frm(0, 8'h04, 0);
      unhalt();
    end
    cmd(8'h31, 3, 0, 0);
    frm(0, 8'h00, 32'h8);
    q_add(4, 1, 0, 2'h2);
    q_add(5, 1, 1, 2'h0);
    settle(30);
    chk("frame_valid", 0, frame_valid);
    chk("halted", 0, halted);
    chk("outstanding_tags", 32'h30, outstanding_tags);
    cmd(8'h00, 6, 0, 0);
    frm(0, 8'h00, 32'h70);
    rst_n = 0;
    settle(2);
    rst_n = 1;
    settle(2);
    chk("rd_nc", 1, read_deadline_no_continue);
    chk("wr_nc", 1, write_deadline_no_continue);
    power_on_rst_n = 0;
    settle(2);
    power_on_rst_n = 1;
    settle(2);
    chk("rd_nc", 0, read_deadline_no_continue);
    chk("wr_nc", 0, write_deadline_no_continue);
  endtask
  initial begin
    settle(16);
    rst_n = 1;
    power_on_rst_n = 1;
    settle(2);
    t_abort();
    stall = 3;
    t_reject();
    stall = 1;
    t_dead();
    summarize();
  end
  initial begin
    #2000000;
    n_fail++;
    summarize();
  end
endmodule // nadr_responder_tb
